// ### logic/ucp_cmd_if.sv
/*
 ucp_cmd_if: serial command interpreter. receives request frames on
 a uart line, keeps the command registers, drives a nonvolatile store
 port and sends read data or receiving-code frames back.
 assumes: rx_i is asynchronous; the store port answers on mclk with a
 one-cycle nv_ack_i pulse per request; software port on mclk.

*/
`timescale 1ns/1ns
`default_nettype none
module ucp_cmd_if #(
    parameter logic [31:0] TIMEOUT_CYCLES = ucp_pkg::TIMEOUT_CYC,
    parameter logic [15:0] BIT_CYCLES = 16'h0000 // nonzero overrides rate
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rx_i,
    output logic tx_o,
    output logic nv_req_o,
    output logic nv_we_o,
    output logic [8:0] nv_addr_o,
    output logic [7:0] nv_wdata_o,
    input wire logic nv_ack_i,
    input wire logic nv_err_i,
    input wire logic [7:0] nv_rdata_i,
    output logic loaded_o,
    input wire logic [8:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_we,
    input wire logic sw_re,
    output logic [7:0] sw_rdata
);

    typedef struct packed {
        ucp_pkg::ucp_state_type ps;
        logic [2:0] rx_sync;
        logic rx_lvl;
        logic rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_vld;
        logic [7:0] rx_byte;
        logic tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic tx_line;
        logic [31:0] to_cnt;
        logic [7:0] hdr;
        logic [7:0] cmd;
        logic [7:0] len;
        logic [7:0] cnt;
        logic ovf;
        logic [ucp_pkg::BUF_DEPTH-1:0][7:0] dbuf;
        logic [3:0][7:0] rep;
        logic [2:0] rep_i;
        logic [8:0] ld_i;
        logic loaded;
        logic nv_req;
        logic nv_we;
        logic [8:0] nv_addr;
        logic [7:0] nv_wdata;
        logic nv_fail;
        logic [7:0] sw_rdata;
        logic [ucp_pkg::REG_COUNT-1:0][7:0] regs;
    } ucp_st_type;

    ucp_st_type st_r;
    ucp_st_type st_nxt;

    // short reply frame: start, length 00H, code, end
    function automatic logic [3:0][7:0] code_rep(input logic [7:0] code);
        code_rep = {ucp_pkg::EOF_BYTE, code, ucp_pkg::LEN_NONE,
                    ucp_pkg::SOF_BYTE};
    endfunction

    // bit period from the communication mode register
    function automatic logic [15:0] baud_div(input logic [1:0] mode);
        case (mode)
            2'h0: baud_div = ucp_pkg::DIV_9600;
            2'h1: baud_div = ucp_pkg::DIV_38400;
            2'h2: baud_div = ucp_pkg::DIV_57600;
            default: baud_div = ucp_pkg::DIV_115200;
        endcase
    endfunction

    // all next-state logic
    always_comb begin
        logic [15:0] div;
        logic bank;
        logic is_wr;
        logic is_pg1;
        logic [8:0] base;
        logic in_frame;
        div = '0;
        bank = 1'b0;
        is_wr = 1'b0;
        is_pg1 = 1'b0;
        base = '0;
        in_frame = 1'b0;
        st_nxt = st_r;
        div = (BIT_CYCLES != 16'h0000) ? BIT_CYCLES :
            baud_div(st_r.regs[ucp_pkg::COMM_MODE_ADDR][1:0]);
        bank = (st_r.hdr[7:2] == ucp_pkg::DEV_EXT);
        is_wr = st_r.hdr[ucp_pkg::HDR_RW_BIT];
        is_pg1 = st_r.hdr[ucp_pkg::HDR_PAGE_BIT];
        base = {bank, st_r.cmd};
        st_nxt.rx_vld = 1'b0;
        // three-stage input sync, level taken when stages 2 and 3 agree
        st_nxt.rx_sync = {st_r.rx_sync[1:0], rx_i};
        if (st_r.rx_sync[1] == st_r.rx_sync[2]) begin
            st_nxt.rx_lvl = st_r.rx_sync[2];
        end

        // receiver: start, 8 data lsb first, one stop, no parity
        if (!st_r.rx_busy) begin
            if (!st_r.rx_lvl) begin
                st_nxt.rx_busy = 1'b1;
                st_nxt.rx_cnt = div >> 1; // sample mid bit
                st_nxt.rx_bit = '0;
            end
        end else if (st_r.rx_cnt != '0) begin
            st_nxt.rx_cnt = st_r.rx_cnt - 16'h0001;
        end else begin
            st_nxt.rx_cnt = div - 16'h0001;
            st_nxt.rx_bit = st_r.rx_bit + 4'h1;
            if (st_r.rx_bit == 4'h0) begin
                if (st_r.rx_lvl) begin
                    st_nxt.rx_busy = 1'b0; // glitch, not a start bit
                end
            end else if (st_r.rx_bit == ucp_pkg::UART_LAST_BIT) begin
                st_nxt.rx_busy = 1'b0;
                if (st_r.rx_lvl) begin
                    st_nxt.rx_vld = 1'b1;
                    st_nxt.rx_byte = st_r.rx_sh;
                end
            end else begin
                st_nxt.rx_sh = {st_r.rx_lvl, st_r.rx_sh[7:1]};
            end
        end

        // transmitter shifts out start, data, stop
        if (st_r.tx_busy) begin
            if (st_r.tx_cnt != '0) begin
                st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
            end else if (st_r.tx_bit == ucp_pkg::UART_LAST_BIT) begin
                st_nxt.tx_busy = 1'b0;
            end else begin
                st_nxt.tx_cnt = div - 16'h0001;
                st_nxt.tx_bit = st_r.tx_bit + 4'h1;
                st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
            end
        end

        // store acknowledge drops the request
        if (nv_ack_i) begin
            st_nxt.nv_req = 1'b0;
        end

        // inter-byte timeout while a request frame is open
        in_frame = (st_r.ps == ucp_pkg::PS_DEV) ||
                   (st_r.ps == ucp_pkg::PS_CMD) ||
                   (st_r.ps == ucp_pkg::PS_LEN) ||
                   (st_r.ps == ucp_pkg::PS_DATA) ||
                   (st_r.ps == ucp_pkg::PS_EOF);
        if (st_r.rx_vld || !in_frame) begin
            st_nxt.to_cnt = '0;
        end else begin
            st_nxt.to_cnt = st_r.to_cnt + 32'h1;
        end

        // protocol sequencer
        case (st_r.ps)
            ucp_pkg::PS_LOAD: begin
                // copy store contents into the registers, except NV_CTRL_ADDR and reads answered with an error
                if (!st_r.nv_req) begin
                    st_nxt.nv_req = 1'b1;
                    st_nxt.nv_we = 1'b0;
                    st_nxt.nv_addr = st_r.ld_i;
                end else if (nv_ack_i) begin
                    if (!nv_err_i && st_r.ld_i != ucp_pkg::NV_CTRL_ADDR) begin
                        st_nxt.regs[st_r.ld_i] = nv_rdata_i;
                    end
                    if (st_r.ld_i == ucp_pkg::LAST_ADDR) begin
                        st_nxt.ps = ucp_pkg::PS_IDLE;
                        st_nxt.loaded = 1'b1;
                    end else begin
                        st_nxt.ld_i = st_r.ld_i + 9'h001;
                    end
                end
            end
            ucp_pkg::PS_IDLE: begin
                if (st_r.rx_vld && st_r.rx_byte == ucp_pkg::SOF_BYTE) begin
                    st_nxt.ps = ucp_pkg::PS_DEV;
                end
            end
            ucp_pkg::PS_DEV: begin
                if (st_r.rx_vld) begin
                    st_nxt.hdr = st_r.rx_byte;
                    st_nxt.ps = ucp_pkg::PS_CMD;
                end
            end
            ucp_pkg::PS_CMD: begin
                if (st_r.rx_vld) begin
                    st_nxt.cmd = st_r.rx_byte;
                    st_nxt.ps = ucp_pkg::PS_LEN;
                end
            end
            ucp_pkg::PS_LEN: begin
                if (st_r.rx_vld) begin
                    st_nxt.len = st_r.rx_byte;
                    st_nxt.cnt = '0;
                    st_nxt.ovf = 1'b0;
                    if (is_wr && st_r.rx_byte == '0) begin
                        st_nxt.ps = ucp_pkg::PS_EOF;
                    end else begin
                        st_nxt.ps = ucp_pkg::PS_DATA;
                    end
                end
            end
            ucp_pkg::PS_DATA: begin
                if (st_r.rx_vld) begin
                    if (st_r.cnt < ucp_pkg::BUF_DEPTH_B) begin
                        st_nxt.dbuf[st_r.cnt[3:0]] = st_r.rx_byte;
                    end else begin
                        st_nxt.ovf = 1'b1;
                    end
                    st_nxt.cnt = st_r.cnt + 8'h01;
                    // a read carries one ignored byte
                    if (!is_wr || st_r.cnt + 8'h01 == st_r.len) begin
                        st_nxt.ps = ucp_pkg::PS_EOF;
                    end
                end
            end
            ucp_pkg::PS_EOF: begin
                if (st_r.rx_vld) begin
                    if (st_r.rx_byte == ucp_pkg::EOF_BYTE) begin
                        st_nxt.ps = ucp_pkg::PS_EXEC;
                    end else begin
                        st_nxt.rep = code_rep(ucp_pkg::RC_FRAME);
                        st_nxt.rep_i = '0;
                        st_nxt.ps = ucp_pkg::PS_REPLY;
                    end
                end
            end
            ucp_pkg::PS_EXEC: begin
                st_nxt.rep_i = '0;
                st_nxt.ps = ucp_pkg::PS_REPLY;
                st_nxt.cnt = '0;
                st_nxt.nv_fail = 1'b0;
                if (st_r.hdr[7:2] != ucp_pkg::DEV_BASIC && !bank) begin
                    st_nxt.rep = code_rep(ucp_pkg::RC_CMD_ERR);
                end else if (st_r.ovf) begin
                    st_nxt.rep = code_rep(ucp_pkg::RC_FRAME);
                end else if (!is_wr && !is_pg1) begin
                    st_nxt.rep = {ucp_pkg::EOF_BYTE, st_r.regs[base],
                                  ucp_pkg::LEN_ONE,
                                  ucp_pkg::SOF_BYTE};
                end else if (!is_wr) begin
                    st_nxt.ps = ucp_pkg::PS_NVOP;
                end else if (!is_pg1) begin
                    // page 0 write: registers only, consecutive numbers
                    for (int k = 0; k < ucp_pkg::BUF_DEPTH; k++) begin
                        if (8'(k) < st_r.len) begin
                            st_nxt.regs[{bank, 8'(st_r.cmd + 8'(k))}] =
                                st_r.dbuf[k];
                        end
                    end
                    st_nxt.rep = code_rep(ucp_pkg::RC_OK);
                end else if (!st_r.regs[ucp_pkg::NV_CTRL_ADDR][ucp_pkg::NV_EN_BIT]) begin
                    st_nxt.rep = code_rep(ucp_pkg::REJECTED_CODE);
                end else begin
                    st_nxt.ps = ucp_pkg::PS_NVOP;
                end
            end
            ucp_pkg::PS_NVOP: begin
                if (!is_wr) begin
                    // store read
                    if (!st_r.nv_req) begin
                        st_nxt.nv_req = 1'b1;
                        st_nxt.nv_we = 1'b0;
                        st_nxt.nv_addr = base;
                    end else if (nv_ack_i) begin
                        st_nxt.ps = ucp_pkg::PS_REPLY;
                        if (nv_err_i) begin
                            st_nxt.rep = code_rep(ucp_pkg::RC_PERIPH);
                        end else begin
                            st_nxt.rep = {ucp_pkg::EOF_BYTE, nv_rdata_i,
                                          ucp_pkg::LEN_ONE,
                                          ucp_pkg::SOF_BYTE};
                        end
                    end
                end else if (!st_r.nv_req) begin
                    if (st_r.cnt == st_r.len) begin
                        // whole run written: disarm, report
                        st_nxt.regs[ucp_pkg::NV_CTRL_ADDR][ucp_pkg::NV_EN_BIT] =
                            1'b0;
                        st_nxt.rep = code_rep(st_r.nv_fail ?
                            ucp_pkg::RC_NV_FAIL : ucp_pkg::RC_OK);
                        st_nxt.ps = ucp_pkg::PS_REPLY;
                    end else begin
                        st_nxt.nv_req = 1'b1;
                        st_nxt.nv_we = 1'b1;
                        st_nxt.nv_addr = {bank, 8'(st_r.cmd + st_r.cnt)};
                        st_nxt.nv_wdata = st_r.dbuf[st_r.cnt[3:0]];
                    end
                end else if (nv_ack_i) begin
                    st_nxt.nv_fail = st_r.nv_fail | nv_err_i;
                    st_nxt.cnt = st_r.cnt + 8'h01;
                end
            end
            ucp_pkg::PS_REPLY: begin
                // send the four reply bytes one after another
                if (!st_r.tx_busy) begin
                    if (st_r.rep_i == ucp_pkg::REP_BYTES) begin
                        st_nxt.ps = ucp_pkg::PS_IDLE;
                    end else begin
                        st_nxt.tx_busy = 1'b1;
                        st_nxt.tx_cnt = div - 16'h0001;
                        st_nxt.tx_bit = '0;
                        st_nxt.tx_sh = {1'b1, st_r.rep[st_r.rep_i[1:0]],
                                        1'b0};
                        st_nxt.rep_i = st_r.rep_i + 3'h1;
                    end
                end
            end
            default: begin
                st_nxt.ps = ucp_pkg::PS_IDLE;
            end
        endcase

        // timeout closes a half-received frame
        if (in_frame && !st_r.rx_vld && st_r.to_cnt >= TIMEOUT_CYCLES) begin
            st_nxt.rep = code_rep(ucp_pkg::RC_TIMEOUT);
            st_nxt.rep_i = '0;
            st_nxt.ps = ucp_pkg::PS_REPLY;
        end

        // software port, after hardware so a software write wins
        if (sw_we) begin
            st_nxt.regs[sw_addr] = sw_wdata;
        end
        if (sw_re) begin
            st_nxt.sw_rdata = st_r.regs[sw_addr];
        end

        st_nxt.tx_line = st_nxt.tx_busy ? st_nxt.tx_sh[0] : ucp_pkg::LINE_IDLE;
    end

    // state register with clock enable
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
            st_r.ps <= ucp_pkg::PS_LOAD;
            st_r.rx_sync <= {3{ucp_pkg::LINE_IDLE}};
            st_r.rx_lvl <= ucp_pkg::LINE_IDLE;
            st_r.tx_line <= ucp_pkg::LINE_IDLE;
            st_r.regs <= {ucp_pkg::REG_COUNT{ucp_pkg::REG_RST}};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign tx_o = st_r.tx_line;
    assign nv_req_o = st_r.nv_req;
    assign nv_we_o = st_r.nv_we;
    assign nv_addr_o = st_r.nv_addr;
    assign nv_wdata_o = st_r.nv_wdata;
    assign loaded_o = st_r.loaded;
    assign sw_rdata = st_r.sw_rdata;

endmodule // ucp_cmd_if
`default_nettype wire

// ### logic/ucp_pkg.sv
/*
 ucp_pkg: constants, codes and state encodings for the serial
 command interpreter of the camera.
 assumes a single 250 MHz clock shared by all users of the package.
*/
`default_nettype none
package ucp_pkg;
    // clock rate and serial timing
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD_9600 = 9600;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_57600 = 57600;
    localparam int BAUD_115200 = 115200;
    localparam logic [15:0] DIV_9600 = 16'(CLK_HZ / BAUD_9600);
    localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / BAUD_38400);
    localparam logic [15:0] DIV_57600 = 16'(CLK_HZ / BAUD_57600);
    localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / BAUD_115200);
    localparam logic [3:0] UART_LAST_BIT = 4'h9;
    // inter-byte timeout inside a request frame
    localparam int TIMEOUT_MS = 10;
    localparam logic [31:0] TIMEOUT_CYC = 32'(CLK_HZ / 1000 * TIMEOUT_MS);
    // frame bytes
    localparam logic [7:0] SOF_BYTE = 8'h02;
    localparam logic [7:0] EOF_BYTE = 8'h03;
    localparam logic [7:0] LEN_NONE = 8'h00;
    localparam logic [7:0] LEN_ONE = 8'h01;
    localparam logic [5:0] DEV_BASIC = 6'h00;
    localparam logic [5:0] DEV_EXT = 6'h20;
    localparam int HDR_RW_BIT = 1;
    localparam int HDR_PAGE_BIT = 0;
    // receiving codes
    localparam logic [7:0] RC_OK = 8'h01;
    localparam logic [7:0] REJECTED_CODE = 8'h10;
    localparam logic [7:0] RC_PERIPH = 8'h11;
    localparam logic [7:0] RC_CMD_ERR = 8'h12;
    localparam logic [7:0] RC_FRAME = 8'h13;
    localparam logic [7:0] RC_TIMEOUT = 8'h14;
    localparam logic [7:0] RC_NV_FAIL = 8'h17;
    // command register space
    localparam int REG_COUNT = 512;
    localparam logic [8:0] NV_CTRL_ADDR = 9'h080;
    localparam int NV_EN_BIT = 0;
    localparam logic [8:0] COMM_MODE_ADDR = 9'h014;
    localparam logic [8:0] LAST_ADDR = 9'h1ff;
    localparam int BUF_DEPTH = 16;
    localparam logic [7:0] BUF_DEPTH_B = 8'h10;
    localparam logic [2:0] REP_BYTES = 3'h4;
    // reset values
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [7:0] REG_RST = 8'h00;
    // protocol states, gray from PS_LOAD to PS_EXEC and on through PS_NVOP to PS_REPLY
    typedef enum logic [3:0] {
        PS_LOAD = 4'h0,
        PS_IDLE = 4'h1,
        PS_DEV = 4'h3,
        PS_CMD = 4'h2,
        PS_LEN = 4'h6,
        PS_DATA = 4'h7,
        PS_EOF = 4'h5,
        PS_EXEC = 4'h4,
        PS_NVOP = 4'hc,
        PS_REPLY = 4'hd
    } ucp_state_type;
endpackage
`default_nettype wire

// ### sim/ucp_nv_model.sv
/*
 ucp_nv_model: behavioural nonvolatile store for the interpreter.
 assumes one request outstanding, held until the one-cycle ack.
*/
`timescale 1ns/1ns
`default_nettype none
module ucp_nv_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic nv_req,
    input wire logic nv_we,
    input wire logic [8:0] nv_addr,
    input wire logic [7:0] nv_wdata,
    output logic nv_ack,
    output logic nv_err,
    output logic [7:0] nv_rdata
);
    logic [7:0] mem [512];
    logic done = 1'b0;
    logic fail_all = 1'b0;
    int cnt = 0;
    int dly = 0;
    initial begin
        nv_ack = 1'b0;
        nv_err = 1'b0;
        nv_rdata = 8'h5a;
    end
    // one answer per request after a random wait of 0 to 3 cycles
    always @(posedge mclk) begin
        nv_ack <= 1'b0;
        nv_err <= 1'b0;
        if (rst || !nv_req) begin
            done <= 1'b0;
            cnt <= 0;
            nv_rdata <= ~nv_rdata; // data not held outside the ack
        end else if (!done && cnt < dly) begin
            cnt <= cnt + 1;
            nv_rdata <= ~nv_rdata;
        end else if (!done) begin
            nv_ack <= 1'b1;
            nv_err <= fail_all;
            done <= 1'b1;
            dly <= int'($urandom % 4);
            if (nv_we) begin
                mem[nv_addr] <= nv_wdata;
                nv_rdata <= ~nv_rdata;
            end else begin
                nv_rdata <= mem[nv_addr];
            end
        end else begin
            nv_rdata <= ~nv_rdata;
        end
    end
endmodule // ucp_nv_model
`default_nettype wire

// ### sim/ucp_monitor.sv
/*
 ucp_monitor: port checks of the serial command interpreter.
 assumes one clock mclk, sync active-high rst, bit length BIT_LEN.
*/
`timescale 1ns/1ns
`default_nettype none
module ucp_monitor #(
    parameter logic [15:0] BIT_CYCLES = 16'h0000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rx_i,
    input wire logic tx_o,
    input wire logic nv_req_o,
    input wire logic nv_we_o,
    input wire logic [8:0] nv_addr_o,
    input wire logic [7:0] nv_wdata_o,
    input wire logic nv_ack_i,
    input wire logic nv_err_i,
    input wire logic [7:0] nv_rdata_i,
    input wire logic loaded_o,
    input wire logic [8:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_we,
    input wire logic sw_re,
    input wire logic [7:0] sw_rdata
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    localparam int BIT_LEN = (BIT_CYCLES != 16'h0000) ?
        int'(BIT_CYCLES) : int'(ucp_pkg::DIV_115200);
    int unsigned low_cnt;
    // length of the current low run on the serial output
    always_ff @(posedge mclk) begin
        if (rst || tx_o) low_cnt <= 0;
        else low_cnt <= low_cnt + 1;
    end
    property p_req_drop;
        nv_req_o && nv_ack_i |=> !nv_req_o;
    endproperty
    property p_req_hold;
        nv_req_o && !nv_ack_i |=>
            nv_req_o && $stable({nv_we_o, nv_addr_o, nv_wdata_o});
    endproperty
    property p_load_read;
        !loaded_o && nv_req_o |-> !nv_we_o;
    endproperty
    property p_load_quiet;
        !loaded_o |-> tx_o;
    endproperty
    property p_loaded_keep;
        loaded_o |=> loaded_o;
    endproperty
    property p_sw_echo;
        sw_we ##1 (sw_re && sw_addr == $past(sw_addr)) |=>
            sw_rdata == $past(sw_wdata, 2);
    endproperty
    property p_sw_hold;
        !sw_re |=> $stable(sw_rdata);
    endproperty
    property p_bit_len;
        loaded_o && $rose(tx_o) |->
            (low_cnt % BIT_LEN) == 0;
    endproperty
    property p_freeze;
        !ce |=> $stable({tx_o, nv_req_o, loaded_o});
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("req held");
    a_req_hold: assert property (p_req_hold) else $error("req moved");
    a_load_read: assert property (p_load_read) else $error("load write");
    a_load_quiet: assert property (p_load_quiet) else $error("tx early");
    a_loaded_keep: assert property (p_loaded_keep) else $error("loaded fell");
    a_sw_echo: assert property (p_sw_echo) else $error("sw readback");
    a_sw_hold: assert property (p_sw_hold) else $error("rdata moved");
    a_bit_len: assert property (p_bit_len) else $error("bit length");
    a_freeze: assert property (p_freeze) else $error("ce ignored");
    c_nv_write: cover property (nv_req_o && nv_we_o && nv_ack_i);
    c_loaded: cover property ($rose(loaded_o));
    c_tx_start: cover property ($fell(tx_o));
endmodule // ucp_monitor
bind ucp_cmd_if ucp_monitor #(.BIT_CYCLES(BIT_CYCLES))
    ucp_monitor_inst (.mclk(mclk), .rst(rst),
    .ce(ce), .rx_i(rx_i), .tx_o(tx_o), .nv_req_o(nv_req_o),
    .nv_we_o(nv_we_o), .nv_addr_o(nv_addr_o), .nv_wdata_o(nv_wdata_o),
    .nv_ack_i(nv_ack_i), .nv_err_i(nv_err_i), .nv_rdata_i(nv_rdata_i),
    .loaded_o(loaded_o), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata));
`default_nettype wire

// ### sim/uart_camera_command_protocol_tb.sv
/*
 uart_camera_command_protocol_tb: serial frames against the interpreter.
 assumes the bit period is shortened to BIT cycles through BIT_CYCLES.
*/
`timescale 1ns/1ns
`default_nettype none
module uart_camera_command_protocol_tb;
    localparam int BIT = 16;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, rx_i = 1'b1;
    logic sw_we = 1'b0, sw_re = 1'b0, tx_o, nv_req_o, nv_we_o, loaded_o;
    logic nv_ack_i, nv_err_i;
    logic [8:0] sw_addr = 9'h000, nv_addr_o;
    logic [7:0] sw_wdata = 8'h00, sw_rdata, nv_wdata_o, nv_rdata_i;
    int fails = 0, compares = 0;
    always #2 mclk = ~mclk;
    ucp_cmd_if #(.TIMEOUT_CYCLES(32'h0000_07d0), .BIT_CYCLES(16'(BIT)))
        ucp_cmd_if_inst (
        .mclk(mclk), .rst(rst), .ce(ce), .rx_i(rx_i), .tx_o(tx_o),
        .nv_req_o(nv_req_o), .nv_we_o(nv_we_o), .nv_addr_o(nv_addr_o),
        .nv_wdata_o(nv_wdata_o), .nv_ack_i(nv_ack_i), .nv_err_i(nv_err_i),
        .nv_rdata_i(nv_rdata_i), .loaded_o(loaded_o), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re),
        .sw_rdata(sw_rdata));
    ucp_nv_model ucp_nv_model_inst (.mclk(mclk), .rst(rst),
        .nv_req(nv_req_o), .nv_we(nv_we_o), .nv_addr(nv_addr_o),
        .nv_wdata(nv_wdata_o), .nv_ack(nv_ack_i), .nv_err(nv_err_i),
        .nv_rdata(nv_rdata_i));
    // header byte from device code and the two access bits
    function automatic logic [7:0] hdr(input logic [5:0] dev,
            input logic w, input logic p);
        return {dev, w, p};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one software port cycle, strobes stay until the next call
    task automatic bus(input logic w, input logic r, input logic [8:0] a,
            input logic [7:0] d);
        @(posedge mclk);
        sw_we <= w;
        sw_re <= r;
        sw_addr <= a;
        sw_wdata <= d;
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1 chk(sw_rdata, e);
    endtask
    // host character: start, eight bits low first, stop
    task automatic tx_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_i <= f[i];
            repeat (BIT) @(posedge mclk);
        end
    endtask
    task automatic rx_byte(output logic [7:0] b);
        int n;
        n = 0;
        while (tx_o !== 1'b0 && n < 8000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 8000) begin
            fails++;
            tally_and_finish();
        end
        repeat (BIT / 2) @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge mclk);
            b[i] = tx_o;
        end
        repeat (BIT) @(negedge mclk);
        chk({7'h00, tx_o}, 8'h01);
    endtask
    // send a request and check the four-byte reply
    task automatic xfer(input logic [7:0] q[$], input logic [7:0] len,
            input logic [7:0] code);
        logic [7:0] r [4];
        fork
            foreach (q[i]) tx_byte(q[i]);
            for (int k = 0; k < 4; k++) rx_byte(r[k]);
        join
        chk(r[0], ucp_pkg::SOF_BYTE);
        chk(r[1], len);
        chk(r[2], code);
        chk(r[3], ucp_pkg::EOF_BYTE);
        repeat (BIT) @(posedge mclk);
    endtask
    // main sequence
    initial begin
        logic [7:0] c, d, e, s, t;
        void'($urandom(10537));
        for (int i = 0; i < 512; i++)
            ucp_nv_model_inst.mem[i] = 8'($urandom);
        ucp_nv_model_inst.mem[9'h014] = 8'h03;
        ucp_nv_model_inst.mem[9'h080] = 8'h01;
        s = ucp_nv_model_inst.mem[9'h010];
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        for (int n = 0; loaded_o !== 1'b1; n++) begin
            if (n > 10000) begin
                fails++;
                tally_and_finish();
            end
            @(posedge mclk);
        end
        rd_chk(9'h010, s);
        rd_chk(ucp_pkg::NV_CTRL_ADDR, 8'h00);
        rd_chk(ucp_pkg::COMM_MODE_ADDR, 8'h03);
        @(posedge mclk) ce <= 1'b0;
        repeat (3) @(posedge mclk);
        ce <= 1'b1;
        $display("test load done");
        c = 8'($urandom_range(8'h7e, 8'h10));
        d = 8'($urandom);
        e = ucp_nv_model_inst.mem[{1'b1, c}];
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_EXT, 1'b1, 1'b0), c,
            8'h01, d, ucp_pkg::EOF_BYTE}, 8'h00, ucp_pkg::RC_OK);
        rd_chk({1'b1, c}, d);
        bus(1'b1, 1'b0, {1'b1, c}, ~d);
        rd_chk({1'b1, c}, ~d);
        chk(ucp_nv_model_inst.mem[{1'b1, c}], e);
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_EXT, 1'b0, 1'b0), c,
            8'($urandom), 8'($urandom), ucp_pkg::EOF_BYTE}, 8'h01, ~d);
        $display("test page0 done");
        e = ucp_nv_model_inst.mem[{1'b0, c}];
        t = 8'($urandom);
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_BASIC, 1'b1, 1'b1), c,
            8'h01, t, ucp_pkg::EOF_BYTE}, 8'h00, ucp_pkg::REJECTED_CODE);
        chk(ucp_nv_model_inst.mem[{1'b0, c}], e);
        bus(1'b1, 1'b0, ucp_pkg::NV_CTRL_ADDR, 8'h01);
        bus(1'b0, 1'b0, 9'h000, 8'h00);
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_BASIC, 1'b1, 1'b1), c,
            8'h02, d, t, ucp_pkg::EOF_BYTE}, 8'h00, ucp_pkg::RC_OK);
        chk(ucp_nv_model_inst.mem[{1'b0, c}], d);
        chk(ucp_nv_model_inst.mem[{1'b0, 8'(c + 8'h01)}], t);
        rd_chk(ucp_pkg::NV_CTRL_ADDR, 8'h00);
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_BASIC, 1'b0, 1'b1), c,
            8'h01, 8'h00, ucp_pkg::EOF_BYTE}, 8'h01, d);
        $display("test store done");
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_BASIC, 1'b1, 1'b0), c,
            8'h01, d, 8'h55}, 8'h00, ucp_pkg::RC_FRAME);
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_BASIC, 1'b1, 1'b0)},
            8'h00, ucp_pkg::RC_TIMEOUT);
        xfer('{ucp_pkg::SOF_BYTE, hdr(6'h01, 1'b1, 1'b0), c, 8'h01, d,
            ucp_pkg::EOF_BYTE}, 8'h00, ucp_pkg::RC_CMD_ERR);
        ucp_nv_model_inst.fail_all = 1'b1;
        bus(1'b1, 1'b0, ucp_pkg::NV_CTRL_ADDR, 8'h01);
        bus(1'b0, 1'b0, 9'h000, 8'h00);
        xfer('{ucp_pkg::SOF_BYTE, hdr(ucp_pkg::DEV_BASIC, 1'b1, 1'b1), c,
            8'h01, t, ucp_pkg::EOF_BYTE}, 8'h00, ucp_pkg::RC_NV_FAIL);
        $display("test frame error done");
        tally_and_finish();
    end
endmodule // uart_camera_command_protocol_tb
`default_nettype wire
